/* src/ebtc_top.sv */
// 8-bit timer/counter with shared prescaler and APB register access
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module ebtc_top (
  // Clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External count clock and core state
  input  wire logic        count_clock_pin,
  input  wire logic        sleep,
  // Watchdog side of the prescaler
  input  wire logic        watchdog_tick,
  input  wire logic        watchdog_clear,
  output logic             watchdog_prescaled,
  // Interrupt
  output logic             irq
);
  import ebtc_pkg::*;

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  // Bus state
  ebtc_bus_state_t bus_r;
  ebtc_bus_state_t bus_nxt;
  logic [31:0]     prdata_r;
  logic [31:0]     prdata_nxt;
  logic            pready_r;
  logic            pready_nxt;
  logic            pslverr_r;
  logic            pslverr_nxt;
  // Registers
  logic [7:0]      count_register_r;
  logic [7:0]      count_register_nxt;
  logic [7:0]      intctl_r;
  logic [7:0]      intctl_nxt;
  logic [7:0]      option_r;
  logic [7:0]      option_nxt;
  logic            irq_mask_r;
  logic            irq_mask_nxt;
  logic            irq_r;
  logic            irq_nxt;
  logic            wd_out_r;
  logic            wd_out_nxt;
  // Timing and edge state
  logic [1:0]      phase_r;
  logic [1:0]      phase_nxt;
  logic [1:0]      inhibit_r;
  logic [1:0]      inhibit_nxt;
  logic            pin_s1_r;
  logic            pin_s2_r;
  logic            pin_s3_r;
  logic            pin_level_r;
  logic            pin_level_nxt;
  logic            pin_prev_r;
  logic            sampled_r;
  logic            sampled_nxt;
  logic            sampled_prev_r;
  // Decodes
  ebtc_option_t    opt;
  logic            setup;
  logic            wr_en;
  logic            hit;
  logic            wr_count;
  logic            wr_intctl;
  logic            wr_stat;
  logic            inst_end;
  logic            src_level;
  logic            src_prev;
  logic            ext_edge;
  logic            pre_tick;
  logic            pre_clear;
  logic            pre_level;
  logic            wd_pulse;
  logic            step;
  logic            overflow;

  assign opt      = ebtc_option_t'(option_r);
  assign setup    = psel && !penable;
  // Write takes effect in the access cycle that sees pready high
  assign wr_en    = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wr_count  = wr_en && (paddr == reg_addr(IDX_COUNT));
  assign wr_intctl = wr_en && (paddr == reg_addr(IDX_INTCTL));
  assign wr_stat   = wr_en && (paddr == reg_addr(IDX_IRQ_STAT));
  assign hit = (paddr == reg_addr(IDX_COUNT))    ||
               (paddr == reg_addr(IDX_INTCTL))   ||
               (paddr == reg_addr(IDX_OPTION))   ||
               (paddr == reg_addr(IDX_IRQ_STAT)) ||
               (paddr == reg_addr(IDX_IRQ_MASK));

  // APB slave: one wait-free access phase, error on unmapped address
  always_comb
  begin
    bus_nxt     = bus_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    case (bus_r)
      EBTC_IDLE:
      begin
        if (setup)
        begin
          bus_nxt     = EBTC_ACCESS;
          pready_nxt  = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt  = 32'h0000_0000;
          if (!pwrite && paddr == reg_addr(IDX_COUNT))
            prdata_nxt[7:0] = count_register_r;
          else if (!pwrite && paddr == reg_addr(IDX_INTCTL))
            prdata_nxt[7:0] = intctl_r;
          else if (!pwrite && paddr == reg_addr(IDX_OPTION))
            prdata_nxt[7:0] = option_r;
          else if (!pwrite && paddr == reg_addr(IDX_IRQ_STAT))
            prdata_nxt[IRQ_OVF_BIT] = intctl_r[INT_OVF_FLAG_BIT];
          else if (!pwrite && paddr == reg_addr(IDX_IRQ_MASK))
            prdata_nxt[IRQ_OVF_BIT] = irq_mask_r;
        end
      end
      EBTC_ACCESS:
        bus_nxt = EBTC_IDLE;
      default:
        bus_nxt = EBTC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_r     <= EBTC_IDLE;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      bus_r     <= bus_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Count pin: three flops, level taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_r <= count_clock_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_level_nxt = (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_level_r;

  // Polarity folded in: falling edges become rising ones
  assign src_level = pin_level_r ^ opt.edge_polarity_bit;
  assign src_prev  = pin_prev_r ^ opt.edge_polarity_bit;
  assign ext_edge  = src_level && !src_prev;
  assign inst_end  = (phase_r == PHASE_SLOT_FOUR);

  // Prescaler tick: pin edges in counter mode, cycles in timer mode
  assign pre_tick  = opt.clock_source_select ? ext_edge
                                             : inst_end;
  assign pre_clear = (wr_count && !opt.prescaler_owner_select)
                  || (watchdog_clear && opt.prescaler_owner_select);

  // Shared prescaler; its owner bit routes it one way only
  ebtc_prescaler u_prescaler (
    .pclk           (pclk),
    .presetn        (presetn),
    .ce             (ce),
    .tick           (opt.prescaler_owner_select ? watchdog_tick
                                                : pre_tick),
    .clear          (pre_clear),
    .to_watchdog    (opt.prescaler_owner_select),
    .rate           (opt.prescale_rate_field),
    .count_level    (pre_level),
    .watchdog_pulse (wd_pulse)
  );

  // Phase slots and the sample: prescaler output, or the pin level when the watchdog owns the prescaler
  always_comb
  begin
    phase_nxt   = phase_r + 2'h1;
    sampled_nxt = sampled_r;
    if (phase_r == PHASE_SLOT_TWO || phase_r == PHASE_SLOT_FOUR)
    begin
      if (opt.prescaler_owner_select)
        sampled_nxt = src_level;
      else
        sampled_nxt = pre_level;
    end
  end

  // Step source: direct cycles, or a rising edge of the sample
  always_comb
  begin
    if (!opt.clock_source_select && opt.prescaler_owner_select)
      step = inst_end;
    else
      step = sampled_r && !sampled_prev_r;
  end

  // Count register with write hold-off and sleep stop
  always_comb
  begin
    count_register_nxt = count_register_r;
    inhibit_nxt        = inhibit_r;
    overflow           = 1'b0;
    if (wr_count)
    begin
      count_register_nxt = pwdata[7:0];
      inhibit_nxt        = WRITE_INHIBIT_CYCLES;
    end
    else
    begin
      if (inst_end && inhibit_r != 2'h0)
        inhibit_nxt = inhibit_r - 2'h1;
      if (step && inhibit_r == 2'h0 && !sleep)
      begin
        count_register_nxt = count_register_r + 8'h01;
        overflow           = (count_register_r == 8'hFF);
      end
    end
  end

  // Control registers; a wrap in the clearing cycle keeps the flag
  always_comb
  begin
    intctl_nxt   = intctl_r;
    option_nxt   = option_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_intctl)
      intctl_nxt = pwdata[7:0];
    if (wr_stat && pwdata[IRQ_OVF_BIT])
      intctl_nxt[INT_OVF_FLAG_BIT] = 1'b0;
    if (wr_en && paddr == reg_addr(IDX_OPTION))
      option_nxt = pwdata[7:0];
    if (wr_en && paddr == reg_addr(IDX_IRQ_MASK))
      irq_mask_nxt = pwdata[IRQ_OVF_BIT];
    if (overflow)
      intctl_nxt[INT_OVF_FLAG_BIT] = 1'b1;
    irq_nxt = intctl_nxt[INT_OVF_FLAG_BIT] &&
              intctl_nxt[INT_OVF_EN_BIT] && irq_mask_nxt;
    wd_out_nxt = wd_pulse;
  end

  // Register all timer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_register_r <= RST_COUNT;
      intctl_r         <= RST_INTCTL;
      option_r         <= RST_OPTION;
      irq_mask_r       <= RST_IRQ_MASK;
      irq_r            <= 1'b0;
      wd_out_r         <= 1'b0;
      phase_r          <= 2'h0;
      inhibit_r        <= 2'h0;
      pin_level_r      <= 1'b0;
      pin_prev_r       <= 1'b0;
      // Idle sample: low pin seen through the reset polarity, no false step
      sampled_r        <= RST_OPTION[OPT_EDGE_POL_BIT];
      sampled_prev_r   <= RST_OPTION[OPT_EDGE_POL_BIT];
    end
    else if (ce)
    begin
      count_register_r <= count_register_nxt;
      intctl_r         <= intctl_nxt;
      option_r         <= option_nxt;
      irq_mask_r       <= irq_mask_nxt;
      irq_r            <= irq_nxt;
      wd_out_r         <= wd_out_nxt;
      phase_r          <= phase_nxt;
      inhibit_r        <= inhibit_nxt;
      pin_level_r      <= pin_level_nxt;
      pin_prev_r       <= pin_level_r;
      sampled_r        <= sampled_nxt;
      sampled_prev_r   <= sampled_r;
    end
  end

  // Outputs straight from flops
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign irq                = irq_r;
  assign watchdog_prescaled = wd_out_r;

endmodule

/* src/ebtc_pkg.sv */
// Constants, register map and field layouts of the 8-bit timer/counter
package ebtc_pkg;

  // Printed register indexes; byte address is four times the index
  localparam logic [7:0] IDX_COUNT     = 8'h01;
  localparam logic [7:0] IDX_INTCTL    = 8'h0B;
  localparam logic [7:0] IDX_OPTION    = 8'h81;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hC1;

  // Reset values
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_INTCTL    = 8'h00;
  localparam logic [7:0] RST_OPTION    = 8'hFF;
  localparam logic [0:0] RST_IRQ_MASK  = 1'h1;

  // Field positions
  localparam int OPT_SRC_SEL_BIT  = 5;
  localparam int OPT_EDGE_POL_BIT = 4;
  localparam int OPT_OWNER_BIT    = 3;
  localparam int INT_OVF_EN_BIT   = 5;
  localparam int INT_OVF_FLAG_BIT = 2;
  localparam int IRQ_OVF_BIT      = 0;

  // Phase slots of one instruction cycle, one pclk each
  localparam logic [1:0] PHASE_SLOT_TWO  = 2'h1;
  localparam logic [1:0] PHASE_SLOT_FOUR = 2'h3;

  // Increment hold-off after a count write, in instruction cycles
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

  // Option register layout
  typedef struct packed {
    logic       pullup_off;
    logic       int_edge;
    logic       clock_source_select;
    logic       edge_polarity_bit;
    logic       prescaler_owner_select;
    logic [2:0] prescale_rate_field;
  } ebtc_option_t;

  // APB transfer state
  typedef enum logic [1:0] {
    EBTC_IDLE   = 2'b00,
    EBTC_ACCESS = 2'b01
  } ebtc_bus_state_t;

endpackage

/* src/ebtc_prescaler.sv */
// Shared 8-bit prescaler, owned by the counter or by the watchdog
`timescale 1ns/1ns
module ebtc_prescaler (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Control
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic       to_watchdog,
  input  wire logic [2:0] rate,
  // Outputs
  output logic            count_level,
  output logic            watchdog_pulse
);

  logic [7:0] pre_count_r;
  logic [7:0] pre_count_nxt;
  logic [7:0] wd_mask;

  // Count the incoming ticks; software cannot see this count
  always_comb
  begin
    pre_count_nxt = pre_count_r;
    if (clear)
      pre_count_nxt = 8'h00;
    else if (tick)
      pre_count_nxt = pre_count_r + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_count_r <= 8'h00;
    else if (ce)
      pre_count_r <= pre_count_nxt;
  end

  // Counter side: bit n toggles at 1:2^(n+1)
  assign count_level = pre_count_r[rate];

  // Watchdog side: 1:1 up to 1:128
  assign wd_mask        = (8'h01 << rate) - 8'h01;
  assign watchdog_pulse = to_watchdog && tick &&
                          ((pre_count_r & wd_mask) == wd_mask);

endmodule

/* tb/ebtc_pin_model.sv */
// External clock source on the count pin
`timescale 1ns/1ns
module ebtc_pin_model (
  // Clock
  input  wire logic pclk,
  // Count pin
  output logic      count_clock_pin
);
  // Pin idles low until the first frame
  initial count_clock_pin = 1'b0;

  // Toggle n times, each level held for hold + 1 cycles
  task automatic toggle(input int n, input int hold);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      count_clock_pin <= !count_clock_pin;
      repeat (hold) @(posedge pclk);
    end
  endtask
endmodule

/* tb/ebtc_props.sv */
// Port assertions of the 8-bit timer/counter
`timescale 1ns/1ns
module ebtc_props
  import ebtc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic        sleep,
  input wire logic        watchdog_prescaled,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed write and the prescaler owner it leaves
  logic wr;
  logic own_r;
  logic own_nxt;
  assign wr = ce && psel && penable && pready && pwrite && !pslverr;
  always_comb
  begin
    own_nxt = own_r;
    if (wr && paddr == {2'h0, IDX_OPTION, 2'h0})
      own_nxt = pwdata[OPT_OWNER_BIT];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      own_r <= RST_OPTION[OPT_OWNER_BIT];
    else
      own_r <= own_nxt;
  end
  property p_setup_answer;
    psel && !penable && ce |=> pready;
  endproperty
  a_setup_answer: assert property (p_setup_answer)
    else $error("no pready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused transfer returned data");
  property p_byte_wide;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("read data above bit 7");
  property p_flag_sticky;
    $fell(irq) |-> $past(wr);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("irq fell without a write");
  property p_enable_mask;
    wr && (paddr == {2'h0, IDX_INTCTL, 2'h0} && !pwdata[INT_OVF_EN_BIT]
      || paddr == {2'h0, IDX_IRQ_MASK, 2'h0} && !pwdata[IRQ_OVF_BIT])
      |=> !irq [*2];
  endproperty
  a_enable_mask: assert property (p_enable_mask)
    else $error("irq while disabled");
  property p_sleep_quiet;
    $rose(irq) |-> !$past(sleep) || $past(wr);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("irq rose during sleep");
  property p_prescaler_exclusive;
    !own_r && !$past(own_r) |-> !watchdog_prescaled;
  endproperty
  a_prescaler_exclusive: assert property (p_prescaler_exclusive)
    else $error("watchdog prescaled while counter owns");
endmodule

/* tb/eight_bit_timer_counter_bench.sv */
// Self-checking bench of the 8-bit timer/counter
`timescale 1ns/1ns
module eight_bit_timer_counter_bench;
  import ebtc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_clock_pin;
  logic        sleep = 1'b1;
  logic        ce = 1'b1;
  logic        watchdog_clear = 1'b0;
  logic        wd_run = 1'b1;
  int          wd_ticks = 0;
  int          wd_pulses = 0;
  int          t0;
  int          p0;
  logic        watchdog_tick = 1'b0;
  logic        watchdog_prescaled;
  logic        irq;
  logic [31:0] rd_data;
  logic        err;
  logic [31:0] seed = 32'h6966;
  logic [31:0] wseed = 32'h6966;
  logic [7:0]  c0;
  int          k;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [7:0]  idx_t [6] = '{IDX_COUNT, IDX_INTCTL, IDX_OPTION,
                             IDX_IRQ_STAT, IDX_IRQ_MASK, 8'h20};
  logic [7:0]  rst_t [6] = '{RST_COUNT, RST_INTCTL, RST_OPTION,
                             8'h00, {7'h0, RST_IRQ_MASK}, 8'h00};

  // Design, pin source
  ebtc_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .count_clock_pin,
    .sleep, .watchdog_tick, .watchdog_clear, .watchdog_prescaled,
    .irq);
  ebtc_pin_model pin (.pclk, .count_clock_pin);

  // Clock and random watchdog ticks
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    wseed <= lfsr(wseed);
    watchdog_tick <= wd_run && wseed[0];
    wd_ticks <= wd_ticks + watchdog_tick;
    wd_pulses <= wd_pulses + watchdog_prescaled;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Edges between reads for two prescaled steps, or ten plain
  function automatic int span(input int r);
    return r < 8 ? 16 << r : 40;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx_t[i])
    begin
      xfer(1'b0, idx_t[i], 32'h0);
      check(rd_data, {24'h0, rst_t[i]});
      check({31'h0, err}, {31'h0, i == 5});
    end
    repeat (8)
    begin
      seed = lfsr(seed);
      xfer(1'b1, IDX_COUNT, seed & 32'hFF);
      xfer(1'b0, IDX_COUNT, 32'h0);
      check(rd_data, seed & 32'hFF);
      xfer(1'b1, IDX_INTCTL, seed & 32'hFB);
      xfer(1'b0, IDX_INTCTL, 32'h0);
      check(rd_data, seed & 32'hFB);
      xfer(1'b1, IDX_OPTION, seed >> 8 & 32'hFF);
      xfer(1'b0, IDX_OPTION, 32'h0);
      check(rd_data, seed >> 8 & 32'hFF);
    end
    xfer(1'b1, IDX_INTCTL, 32'h0);
    sleep <= 1'b0;
    // Count write clears an owned prescaler: next step 128 instruction cycles on
    xfer(1'b1, IDX_OPTION, 32'h07);
    xfer(1'b1, IDX_COUNT, 32'h5A);
    repeat (400) @(posedge pclk);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check(rd_data, 32'h5A);
    repeat (300) @(posedge pclk);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check(rd_data, 32'h5B);
    // Timer rates, every prescale code, then none
    for (int r = 0; r < 9; r++)
    begin
      xfer(1'b1, IDX_OPTION, r < 8 ? {29'h0, r[2:0]} : 32'h08);
      repeat (8) @(posedge pclk);
      xfer(1'b0, IDX_COUNT, 32'h0);
      c0 = rd_data[7:0];
      repeat (span(r) - 3) @(posedge pclk);
      xfer(1'b0, IDX_COUNT, 32'h0);
      check({24'h0, rd_data[7:0] - c0}, r < 8 ? 2 : 10);
    end
    // Hold-off after a count write
    seed = lfsr(seed);
    xfer(1'b1, IDX_COUNT, seed & 32'hFF);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check(rd_data, seed & 32'hFF);
    xfer(1'b1, IDX_COUNT, seed & 32'hFF);
    repeat (11) @(posedge pclk);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check(rd_data, seed + 1 & 32'hFF);
    // Counter stopped in sleep
    sleep <= 1'b1;
    xfer(1'b0, IDX_COUNT, 32'h0);
    c0 = rd_data[7:0];
    repeat (37) @(posedge pclk);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check({24'h0, rd_data[7:0]}, {24'h0, c0});
    sleep <= 1'b0;
    // Clock enable low freezes all; 40 enabled cycles give 10 steps
    xfer(1'b0, IDX_COUNT, 32'h0);
    c0 = rd_data[7:0];
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    repeat (37) @(posedge pclk);
    xfer(1'b0, IDX_COUNT, 32'h0);
    check({24'h0, rd_data[7:0] - c0}, 32'hA);
    // Pin edges, rising then falling polarity
    for (int p = 0; p < 2; p++)
    begin
      xfer(1'b1, IDX_OPTION, p == 0 ? 32'h28 : 32'h38);
      seed = lfsr(seed);
      k = seed[2:0] + 1;
      repeat (8) @(posedge pclk);
      xfer(1'b0, IDX_COUNT, 32'h0);
      c0 = rd_data[7:0];
      pin.toggle(2 * k + 1, 4 + seed[5:3]);
      repeat (12) @(posedge pclk);
      xfer(1'b0, IDX_COUNT, 32'h0);
      check({24'h0, rd_data[7:0] - c0}, k + 1);
    end
    // Overflow with mask, enable and both clearing paths
    xfer(1'b1, IDX_OPTION, 32'h08);
    for (int m = 0; m < 3; m++)
    begin
      xfer(1'b1, IDX_INTCTL, m == 2 ? 32'h0 : 32'h20);
      xfer(1'b1, IDX_COUNT, 32'hFE);
      repeat (24) @(posedge pclk);
      check({31'h0, irq}, {31'h0, m != 2});
      xfer(1'b0, IDX_INTCTL, 32'h0);
      check(rd_data, m == 2 ? 32'h04 : 32'h24);
      if (m == 0)
      begin
        xfer(1'b1, IDX_IRQ_MASK, 32'h0);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, IDX_IRQ_MASK, 32'h1);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
      end
      xfer(1'b1, m == 1 ? IDX_IRQ_STAT : IDX_INTCTL, {31'h0, m == 1});
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      xfer(1'b0, IDX_IRQ_STAT, 32'h0);
      check(rd_data, 32'h0);
    end
    // Watchdog ratio from a cleared prescaler, every rate code
    for (int r = 0; r < 8; r++)
    begin
      xfer(1'b1, IDX_OPTION, {28'h0, 1'b1, r[2:0]});
      wd_run <= 1'b0;
      repeat (2) @(posedge pclk);
      watchdog_clear <= 1'b1;
      @(posedge pclk);
      watchdog_clear <= 1'b0;
      wd_run <= 1'b1;
      t0 = wd_ticks;
      p0 = wd_pulses;
      repeat (200) @(posedge pclk);
      wd_run <= 1'b0;
      repeat (4) @(posedge pclk);
      check(wd_pulses - p0, wd_ticks - t0 >> r);
    end
    finish_test();
  end
endmodule

bind ebtc_top ebtc_props u_props (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep,
  .watchdog_prescaled, .irq);
